// ### hw/cse_pkg.sv
package cse_pkg;
	localparam int CSE_ADDR_W = 24;
	localparam int CSE_REG_W = 16;
	localparam int CSE_DREG_W = 32;
	// Operation selected by the issuing stage.
	typedef enum logic [1:0] {
		CSE_OP_NONE,
		CSE_OP_SCOND,
		CSE_OP_SPR,
		CSE_OP_STOR
	} cse_op_t;
	// Condition field encodings.
	localparam logic [3:0] CSE_CC_EQ = 4'h0;
	localparam logic [3:0] CSE_CC_NE = 4'h1;
	localparam logic [3:0] CSE_CC_CS = 4'h2;
	localparam logic [3:0] CSE_CC_CC = 4'h3;
	localparam logic [3:0] CSE_CC_HI = 4'h4;
	localparam logic [3:0] CSE_CC_LS = 4'h5;
	localparam logic [3:0] CSE_CC_GT = 4'h6;
	localparam logic [3:0] CSE_CC_LE = 4'h7;
	localparam logic [3:0] CSE_CC_FS = 4'h8;
	localparam logic [3:0] CSE_CC_FC = 4'h9;
	localparam logic [3:0] CSE_CC_LO = 4'hA;
	localparam logic [3:0] CSE_CC_HS = 4'hB;
	localparam logic [3:0] CSE_CC_LT = 4'hC;
	localparam logic [3:0] CSE_CC_GE = 4'hD;
	// Processor register selectors; single and wide reads share codes.
	localparam logic [4:0] CSE_PR_STATUS = 5'h00;
	localparam logic [4:0] CSE_PR_CFG = 5'h01;
	localparam logic [4:0] CSE_PR_DSR = 5'h02;
	localparam logic [4:0] CSE_PR_INTB_L = 5'h04;
	localparam logic [4:0] CSE_PR_INTB_H = 5'h05;
	localparam logic [4:0] CSE_PR_ISTK_L = 5'h06;
	localparam logic [4:0] CSE_PR_ISTK_H = 5'h07;
	localparam logic [4:0] CSE_PR_USTK_L = 5'h08;
	localparam logic [4:0] CSE_PR_USTK_H = 5'h09;
	localparam logic [4:0] CSE_PR_DCW_L = 5'h0A;
	localparam logic [4:0] CSE_PR_DCW_H = 5'h0B;
	localparam logic [4:0] CSE_PR_CA0_L = 5'h0C;
	localparam logic [4:0] CSE_PR_CA0_H = 5'h0D;
	localparam logic [4:0] CSE_PR_CA1_L = 5'h0E;
	localparam logic [4:0] CSE_PR_CA1_H = 5'h0F;
	// Store widths.
	localparam logic [1:0] CSE_W_BYTE = 2'h0;
	localparam logic [1:0] CSE_W_WORD = 2'h1;
	localparam logic [1:0] CSE_W_DWORD = 2'h2;
	// Addressing modes.
	localparam logic [1:0] CSE_AM_ABS = 2'h0;
	localparam logic [1:0] CSE_AM_REL = 2'h1;
	localparam logic [1:0] CSE_AM_PAIR = 2'h2;
	localparam logic [15:0] CSE_ONE = 16'h0001;
	// Flag positions inside the status word.
	localparam int CSE_FLAG_CARRY = 0;
	localparam int CSE_FLAG_LOW = 2;
	localparam int CSE_FLAG_GENERAL = 5;
	localparam int CSE_FLAG_ZERO = 6;
	localparam int CSE_FLAG_NEGATIVE = 7;
endpackage : cse_pkg

// ### hw/cse_cond.sv
`timescale 1ns/1ps
module cse_cond (
	input wire logic [3:0] cond,
	input wire logic zero_flag,
	input wire logic carry_flag,
	input wire logic low_flag,
	input wire logic negative_flag,
	input wire logic general_flag,
	output logic cond_true,
	output logic cond_legal
);
	import cse_pkg::*;
	always_comb begin
		cond_true = 1'b0;
		cond_legal = 1'b1;
		unique case (cond)
			CSE_CC_EQ: cond_true = zero_flag;
			CSE_CC_NE: cond_true = !zero_flag;
			CSE_CC_CS: cond_true = carry_flag;
			CSE_CC_CC: cond_true = !carry_flag;
			CSE_CC_HI: cond_true = low_flag;
			CSE_CC_LS: cond_true = !low_flag;
			CSE_CC_GT: cond_true = negative_flag;
			CSE_CC_LE: cond_true = !negative_flag;
			CSE_CC_FS: cond_true = general_flag;
			CSE_CC_FC: cond_true = !general_flag;
			CSE_CC_LO: cond_true = !zero_flag && !low_flag;
			CSE_CC_HS: cond_true = zero_flag || low_flag;
			CSE_CC_LT: cond_true = !zero_flag && !negative_flag;
			CSE_CC_GE: cond_true = zero_flag || negative_flag;
			default: cond_legal = 1'b0;
		endcase
	end
endmodule : cse_cond

// ### hw/cse_exec.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - Conditional set writes 1 when the condition holds, else 0.
// - Single-flag conditions test zero, carry, low and general flags.
// - Greater-than is negative flag 1; less-or-equal is negative flag 0.
// - Lower/less-than need both flags 0; the opposites need either flag 1.
// - Special read copies the named processor register to a register or pair.
// - Wide read of a 16-bit register zero-fills the upper half.
// - Single read takes the three words and every low/high half.
// - Wide read takes the three words and every full 32-bit register.
// - Immediate store writes a 4-bit value, zero-extended to store width.
// - Byte store writes only the low byte to the addressed byte.
// - Register-relative address is displacement plus base register.
// - Pair-relative base is upper register above lower, plus displacement.
// - Odd word store splits low byte here and high byte in next word.
// - Even double-word store puts low half first, high half at next word; odd one stores only the low half, split.
module cse_exec (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic issue,
	input wire cse_pkg::cse_op_t op,
	input wire logic [3:0] cond,
	input wire logic [4:0] preg_sel,
	input wire logic wide,
	input wire logic [1:0] st_width,
	input wire logic [1:0] addr_mode,
	input wire logic use_imm,
	input wire logic [3:0] imm4,
	input wire logic [23:0] disp,
	input wire logic [3:0] dest_idx,
	input wire logic [31:0] src_data,
	input wire logic [15:0] base_lo,
	input wire logic [15:0] base_hi,
	input wire logic [15:0] status_word,
	input wire logic [15:0] cfg_word,
	input wire logic [15:0] debug_status_word,
	input wire logic [31:0] interrupt_base,
	input wire logic [31:0] interrupt_stack_ptr,
	input wire logic [31:0] user_stack_ptr,
	input wire logic [31:0] debug_condition_word,
	input wire logic [31:0] compare_addr_zero,
	input wire logic [31:0] compare_addr_one,
	output logic busy,
	output logic rf_we,
	output logic rf_wide,
	output logic [3:0] rf_idx,
	output logic [31:0] rf_data,
	output logic flags_we,
	output logic trap,
	output logic illegal,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic [1:0] mem_be
);
	import cse_pkg::*;
	typedef enum logic [1:0] {
		CSE_IDLE,
		CSE_SECOND
	} cse_state_t;
	cse_state_t state, next_state;
	logic next_busy, next_rf_we, next_rf_wide, next_illegal, next_mem_we;
	logic [3:0] next_rf_idx;
	logic [31:0] next_rf_data;
	logic [23:0] next_mem_addr, pend_addr, next_pend_addr, eff_addr, base;
	logic [15:0] next_mem_wdata, pend_data, next_pend_data;
	logic [1:0] next_mem_be, pend_be, next_pend_be;
	logic [31:0] store_val;
	logic [31:0] preg_val;
	logic preg_ok;
	logic cond_true, cond_legal;
	cse_cond u_cond (
		.cond(cond),
		.zero_flag(status_word[CSE_FLAG_ZERO]),
		.carry_flag(status_word[CSE_FLAG_CARRY]),
		.low_flag(status_word[CSE_FLAG_LOW]),
		.negative_flag(status_word[CSE_FLAG_NEGATIVE]),
		.general_flag(status_word[CSE_FLAG_GENERAL]),
		.cond_true(cond_true),
		.cond_legal(cond_legal)
	);
	// Processor register mux; a wide read names full registers by their low code.
	always_comb begin
		preg_val = 32'h0000_0000;
		preg_ok = 1'b1;
		unique case (preg_sel)
			CSE_PR_STATUS: preg_val = {16'h0000, status_word};
			CSE_PR_CFG: preg_val = {16'h0000, cfg_word};
			CSE_PR_DSR: preg_val = {16'h0000, debug_status_word};
			CSE_PR_INTB_L: preg_val = wide ? interrupt_base : {16'h0000, interrupt_base[15:0]};
			CSE_PR_ISTK_L: preg_val = wide ? interrupt_stack_ptr
				: {16'h0000, interrupt_stack_ptr[15:0]};
			CSE_PR_USTK_L: preg_val = wide ? user_stack_ptr : {16'h0000, user_stack_ptr[15:0]};
			CSE_PR_DCW_L: preg_val = wide ? debug_condition_word
				: {16'h0000, debug_condition_word[15:0]};
			CSE_PR_CA0_L: preg_val = wide ? compare_addr_zero
				: {16'h0000, compare_addr_zero[15:0]};
			CSE_PR_CA1_L: preg_val = wide ? compare_addr_one : {16'h0000, compare_addr_one[15:0]};
			CSE_PR_INTB_H: begin
				preg_val = {16'h0000, interrupt_base[31:16]};
				preg_ok = !wide;
			end
			CSE_PR_ISTK_H: begin
				preg_val = {16'h0000, interrupt_stack_ptr[31:16]};
				preg_ok = !wide;
			end
			CSE_PR_USTK_H: begin
				preg_val = {16'h0000, user_stack_ptr[31:16]};
				preg_ok = !wide;
			end
			CSE_PR_DCW_H: begin
				preg_val = {16'h0000, debug_condition_word[31:16]};
				preg_ok = !wide;
			end
			CSE_PR_CA0_H: begin
				preg_val = {16'h0000, compare_addr_zero[31:16]};
				preg_ok = !wide;
			end
			CSE_PR_CA1_H: begin
				preg_val = {16'h0000, compare_addr_one[31:16]};
				preg_ok = !wide;
			end
			default: preg_ok = 1'b0;
		endcase
	end
	// Address and store data.
	always_comb begin
		unique case (addr_mode)
			CSE_AM_REL: base = {8'h00, base_lo};
			CSE_AM_PAIR: base = {base_hi[7:0], base_lo};
			default: base = 24'h00_0000;
		endcase
		eff_addr = base + disp;
		store_val = use_imm ? {28'h000_0000, imm4} : src_data;
	end
	always_comb begin
		next_state = state;
		next_busy = 1'b0;
		next_rf_we = 1'b0;
		next_rf_wide = 1'b0;
		next_rf_idx = rf_idx;
		next_rf_data = rf_data;
		next_illegal = 1'b0;
		next_mem_we = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_be = 2'h0;
		next_pend_addr = pend_addr;
		next_pend_data = pend_data;
		next_pend_be = pend_be;
		unique case (state)
			CSE_IDLE: begin
				if (issue) begin
					unique case (op)
						CSE_OP_SCOND: begin
							next_rf_idx = dest_idx;
							next_rf_data = {16'h0000, cond_true ? CSE_ONE : 16'h0000};
							next_rf_we = cond_legal;
							next_illegal = !cond_legal;
						end
						CSE_OP_SPR: begin
							next_rf_idx = dest_idx;
							next_rf_data = preg_val;
							next_rf_wide = wide;
							next_rf_we = preg_ok;
							next_illegal = !preg_ok;
						end
						CSE_OP_STOR: begin
							next_mem_we = 1'b1;
							next_mem_addr = {eff_addr[23:1], 1'b0};
							if (st_width == CSE_W_BYTE) begin
								// Only one lane is enabled so the neighbour byte is untouched.
								next_mem_wdata = {store_val[7:0], store_val[7:0]};
								next_mem_be = eff_addr[0] ? 2'h2 : 2'h1;
							end else if (!eff_addr[0]) begin
								next_mem_wdata = store_val[15:0];
								next_mem_be = 2'h3;
								if (st_width == CSE_W_DWORD) begin
									next_pend_addr = eff_addr + 24'h00_0002;
									next_pend_data = store_val[31:16];
									next_pend_be = 2'h3;
									next_state = CSE_SECOND;
									next_busy = 1'b1;
								end
							end else begin
								// Misaligned: low byte in the upper lane, high byte next word.
								next_mem_wdata = {store_val[7:0], 8'h00};
								next_mem_be = 2'h2;
								next_pend_addr = eff_addr + 24'h00_0001;
								next_pend_data = {8'h00, store_val[15:8]};
								next_pend_be = 2'h1;
								next_state = CSE_SECOND;
								next_busy = 1'b1;
							end
						end
						default: ;
					endcase
				end
			end
			CSE_SECOND: begin
				next_mem_we = 1'b1;
				next_mem_addr = pend_addr;
				next_mem_wdata = pend_data;
				next_mem_be = pend_be;
				next_state = CSE_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= CSE_IDLE;
			busy <= 1'b0;
			rf_we <= 1'b0;
			rf_wide <= 1'b0;
			rf_idx <= 4'h0;
			rf_data <= 32'h0000_0000;
			illegal <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 24'h00_0000;
			mem_wdata <= 16'h0000;
			mem_be <= 2'h0;
			pend_addr <= 24'h00_0000;
			pend_data <= 16'h0000;
			pend_be <= 2'h0;
			flags_we <= 1'b0;
			trap <= 1'b0;
		end else begin
			state <= next_state;
			busy <= next_busy;
			rf_we <= next_rf_we;
			rf_wide <= next_rf_wide;
			rf_idx <= next_rf_idx;
			rf_data <= next_rf_data;
			illegal <= next_illegal;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_be <= next_mem_be;
			pend_addr <= next_pend_addr;
			pend_data <= next_pend_data;
			pend_be <= next_pend_be;
			flags_we <= 1'b0;
			trap <= 1'b0;
		end
	end
endmodule : cse_exec

// ### verification/cse_exec_sva.sv
`timescale 1ns/1ps
module cse_exec_sva
	import cse_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic issue,
	input wire cse_pkg::cse_op_t op,
	input wire logic [3:0] cond,
	input wire logic [4:0] preg_sel,
	input wire logic [1:0] st_width,
	input wire logic [1:0] addr_mode,
	input wire logic use_imm,
	input wire logic [23:0] disp,
	input wire logic [31:0] src_data,
	input wire logic [15:0] status_word,
	input wire logic busy,
	input wire logic rf_we,
	input wire logic [31:0] rf_data,
	input wire logic flags_we,
	input wire logic trap,
	input wire logic illegal,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [1:0] mem_be
);
	logic sc;
	logic st;
	assign sc = issue && !busy && op == CSE_OP_SCOND;
	// Absolute register stores only, so the address is known from disp alone.
	assign st = issue && !busy && op == CSE_OP_STOR && !use_imm && addr_mode == CSE_AM_ABS;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	chk_flags_quiet: assert property (!flags_we && !trap)
		else $error("flag write or trap seen");
	chk_scond_value: assert property (sc && cond < 4'hE |=> rf_we && !illegal &&
		rf_data[31:1] == 31'h0) else $error("scond result not 0 or 1");
	chk_eq_zero: assert property (sc && cond == CSE_CC_EQ |=>
		rf_data[0] == $past(status_word[6])) else $error("equal test wrong");
	chk_gt_negative: assert property (sc && cond == CSE_CC_GT |=>
		rf_data[0] == $past(status_word[7])) else $error("greater test wrong");
	chk_lt_both: assert property (sc && cond == CSE_CC_LT |=>
		rf_data[0] == !($past(status_word[6]) || $past(status_word[7])))
		else $error("less test wrong");
	chk_spr_status: assert property (issue && !busy && op == CSE_OP_SPR &&
		preg_sel == CSE_PR_STATUS |=> rf_we && rf_data == {16'h0000, $past(status_word)})
		else $error("status read wrong");
	chk_odd_split: assert property (st && st_width == CSE_W_WORD && disp[0] |=> mem_we &&
		mem_be == 2'h2 && busy && mem_wdata[15:8] == $past(src_data[7:0]) ##1 mem_we &&
		mem_be == 2'h1 && !busy && mem_addr == $past(disp, 2) + 24'h1 &&
		mem_wdata[7:0] == $past(src_data[15:8], 2)) else $error("odd word split wrong");
	chk_dword_halves: assert property (st && st_width == CSE_W_DWORD && !disp[0] |=>
		mem_we && mem_addr == $past(disp) && mem_wdata == $past(src_data[15:0]) ##1 mem_we &&
		mem_addr == $past(disp, 2) + 24'h2 && mem_wdata == $past(src_data[31:16], 2))
		else $error("double word halves wrong");
endmodule : cse_exec_sva
bind cse_exec cse_exec_sva u_sva (.core_clk, .rstn, .issue, .op, .cond, .preg_sel, .st_width,
	.addr_mode, .use_imm, .disp, .src_data, .status_word, .busy, .rf_we, .rf_data, .flags_we,
	.trap, .illegal, .mem_we, .mem_addr, .mem_wdata, .mem_be);

// ### verification/cse_mem_model.sv
`timescale 1ns/1ps
module cse_mem_model (
	input wire logic core_clk,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [1:0] mem_be
);
	// Sparse byte store; a lane left disabled keeps its old byte.
	logic [7:0] mem [int];
	always @(posedge core_clk) begin
		if (mem_we && mem_be[0]) begin
			mem[int'(mem_addr)] = mem_wdata[7:0];
		end
		if (mem_we && mem_be[1]) begin
			mem[int'(mem_addr) + 1] = mem_wdata[15:8];
		end
	end
endmodule : cse_mem_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cse_pkg::*;
	logic core_clk = 0, rstn = 0, issue = 0, wide = 0, use_imm = 0;
	cse_op_t op = CSE_OP_NONE;
	logic [3:0] cond = 4'h0, imm4 = 4'h0, dest_idx = 4'h0, rf_idx;
	logic [4:0] preg_sel = 5'h00;
	logic [1:0] st_width = 2'h0, addr_mode = 2'h0, mem_be;
	logic [23:0] disp = 24'h0, mem_addr, d, ea;
	logic [15:0] base_lo = 16'h0, base_hi = 16'h0, status_word = 16'h0, cfg_word = 16'h0;
	logic [15:0] debug_status_word = 16'h0, mem_wdata, bl, bh;
	logic [31:0] src_data = 32'h0, interrupt_base = 32'h0, interrupt_stack_ptr = 32'h0;
	logic [31:0] user_stack_ptr = 32'h0, debug_condition_word = 32'h0, a, v;
	logic [31:0] compare_addr_zero = 32'h0, compare_addr_one = 32'h0, rf_data, seed = 32'hBF67B813;
	logic [32:0] e;
	logic busy, rf_we, rf_wide, flags_we, trap, illegal, mem_we;
	logic [1:0] tw [5] = '{CSE_W_BYTE, CSE_W_WORD, CSE_W_WORD, CSE_W_DWORD, CSE_W_WORD};
	logic [1:0] tm [5] = '{CSE_AM_REL, CSE_AM_ABS, CSE_AM_PAIR, CSE_AM_ABS, CSE_AM_REL};
	logic dp [5] = '{1, 1, 0, 0, 0};
	logic bp [5] = '{0, 0, 1, 0, 0};
	int failures = 0, checked = 0, c;
	always #4 core_clk = ~core_clk;
	cse_exec u_dut (.core_clk, .rstn, .issue, .op, .cond, .preg_sel, .wide, .st_width, .addr_mode,
		.use_imm, .imm4, .disp, .dest_idx, .src_data, .base_lo, .base_hi, .status_word, .cfg_word,
		.debug_status_word, .interrupt_base, .interrupt_stack_ptr, .user_stack_ptr,
		.debug_condition_word, .compare_addr_zero, .compare_addr_one, .busy, .rf_we, .rf_wide,
		.rf_idx, .rf_data, .flags_we, .trap, .illegal, .mem_we, .mem_addr, .mem_wdata, .mem_be);
	cse_mem_model u_mem (.core_clk, .mem_we, .mem_addr, .mem_wdata, .mem_be);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic cexp(input logic [3:0] k, input logic [15:0] s);
		int p [5] = '{6, 0, 2, 7, 5};
		if (k < 4'hA) return s[p[k >> 1]] ^ k[0];
		return !(s[6] | (k < 4'hC ? s[2] : s[7])) ^ k[0];
	endfunction : cexp
	// Bit 32 flags a selector that must be refused.
	function automatic logic [32:0] sexp(input logic [4:0] k, input logic w);
		logic [31:0] r [6];
		r = '{interrupt_base, interrupt_stack_ptr, user_stack_ptr, debug_condition_word,
			compare_addr_zero, compare_addr_one};
		if (k == 5'h03 || (w && k > 5'h04 && k[0])) return {1'b1, 32'h0};
		if (k < 5'h03) return {17'h0, k == 5'h00 ? status_word : k == 5'h01 ? cfg_word : debug_status_word};
		if (w) return {1'b0, r[(k - 4) >> 1]};
		return {17'h0, k[0] ? r[(k - 4) >> 1][31:16] : r[(k - 4) >> 1][15:0]};
	endfunction : sexp
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			failures++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic fire(input int n);
		issue <= 1'b1;
		@(posedge core_clk);
		issue <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : fire
	task automatic wrap_up();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		failures++;
		wrap_up();
	end
	initial begin
		@(posedge core_clk);
		{interrupt_base, interrupt_stack_ptr, user_stack_ptr} <= {rnd(), rnd(), rnd()};
		{debug_condition_word, compare_addr_zero, compare_addr_one} <= {rnd(), rnd(), rnd()};
		{cfg_word, debug_status_word} <= rnd();
		repeat (7) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			@(posedge core_clk);
			op <= CSE_OP_SCOND;
			cond <= 4'(i % 16);
			dest_idx <= 4'(rnd());
			status_word <= 16'(rnd());
			fire(0);
			check(rf_we, cond < 4'hE);
			check(illegal, cond >= 4'hE);
			check(rf_idx, dest_idx);
			check(rf_wide, 0);
			check(flags_we | trap, 0);
			if (cond < 4'hE) check(rf_data, cexp(cond, status_word));
		end
		$display("condition set test done");
		for (int i = 0; i < 32; i++) begin
			@(posedge core_clk);
			op <= CSE_OP_SPR;
			preg_sel <= 5'(i % 16);
			wide <= i >= 16;
			dest_idx <= 4'(rnd());
			fire(0);
			e = sexp(preg_sel, wide);
			check(rf_we, !e[32]);
			check(illegal, e[32]);
			check(rf_idx, dest_idx);
			if (!e[32]) check(rf_data, e[31:0]);
			if (!e[32]) check(rf_wide, wide);
		end
		$display("special read test done");
		for (int i = 0; i < 15; i++) begin
			c = i % 5;
			a = rnd();
			v = rnd();
			d = {a[23:1], dp[c]};
			bl = {v[15:1], bp[c]};
			bh = v[31:16];
			ea = (tm[c] == CSE_AM_ABS ? 24'h0 : tm[c] == CSE_AM_REL ? {8'h00, bl} : {bh[7:0], bl}) + d;
			@(posedge core_clk);
			op <= CSE_OP_STOR;
			{st_width, addr_mode, use_imm, imm4} <= {tw[c], tm[c], c == 4, a[27:24]};
			{disp, base_lo, base_hi, src_data} <= {d, bl, bh, rnd()};
			fire(0);
			check(busy, tw[c] != CSE_W_BYTE && (ea[0] || tw[c] == CSE_W_DWORD));
			repeat (3) @(posedge core_clk);
			#1;
			v = use_imm ? {28'h0, imm4} : src_data;
			for (int j = 0; j < (1 << tw[c]); j++) begin
				check(u_mem.mem[int'(24'(ea + j))], v[8 * j +: 8]);
			end
			if (c == 0) check(u_mem.mem.exists(int'(ea ^ 24'h1)), 0);
		end
		$display("store test done");
		wrap_up();
	end
endmodule : testbench
